// ---- logic/pci_arb_pkg.sv ----
package pci_arb_pkg;

	// Grant is withdrawn if no cycle has started this many clocks after it
	localparam int unsigned GNT_TIMEOUT_CLKS = 16;
	localparam logic [4:0]  GNT_TIMEOUT_LAST = 5'(GNT_TIMEOUT_CLKS - 1);
	// Clock after the address phase at which subtractive decode claims
	localparam logic [2:0]  SUBTRACTIVE_CLK  = 3'h4;
	// Smallest region covered by a lock, in bytes
	localparam int unsigned LOCK_MIN_BYTES   = 16;
	// Command as it appears on the active-low command/byte-enable pins
	localparam logic [3:0]  CMD_SPECIAL      = 4'h1;
	localparam logic [3:0]  CMD_RESET        = 4'h0;
	localparam logic [2:0]  GNT_N_RESET      = 3'h7;
	localparam logic [1:0]  MASTER_RESET     = 2'h0;
	localparam logic [1:0]  RR_LAST_RESET    = 2'h2;

	typedef enum logic [1:0] {
		ARB_IDLE    = 2'b00,
		ARB_GRANTED = 2'b01,
		ARB_GAP     = 2'b10
	} arb_state_t;

	// Bus pins as sampled, all active-low as on the wire except ad and par
	typedef struct packed {
		logic [2:0]  req_n;
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        lock_n;
		logic        par;
		logic [3:0]  cbe_n;
		logic [31:0] ad;
	} pci_pins_t;

	localparam pci_pins_t PINS_IDLE = '{
		req_n: 3'h7, frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1, devsel_n: 1'b1,
		lock_n: 1'b1, par: 1'b0, cbe_n: 4'hF, ad: 32'h0000_0000};

	// Open-drain or shared pin drive: level and enable
	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_t;

endpackage : pci_arb_pkg

// ---- logic/pci_arbiter_lock_error.sv ----
`timescale 1ns/1ps
module pci_arbiter_lock_error (
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire pci_arb_pkg::pci_pins_t pins,
	input  wire logic                 arb_round_robin,
	input  wire logic                 sys_lock_en,
	input  wire logic                 own_master_busy,
	input  wire logic                 own_target_claim,
	input  wire logic                 parity_check_en,
	input  wire logic                 dram_read_par_err,
	output logic [2:0]                gnt_n,
	output pci_arb_pkg::pin_drive_t   perr_drive,
	output pci_arb_pkg::pin_drive_t   serr_drive,
	output logic                      master_abort,
	output logic                      lock_held,
	output logic [1:0]                lock_owner
);

	typedef struct packed {
		pci_arb_pkg::pci_pins_t  s1;
		pci_arb_pkg::pci_pins_t  s2;
		logic                    frame_q;
		logic                    lock_q;
		pci_arb_pkg::arb_state_t arb;
		logic [2:0]              gnt_n;
		logic [1:0]              cur;
		logic [1:0]              rr_last;
		logic [4:0]              tmo;
		logic                    started;
		logic                    lock_held;
		logic [1:0]              lock_owner;
		logic [3:0]              cmd;
		logic                    in_txn;
		logic                    mst_own;
		logic [2:0]              dcnt;
		logic                    dsel_seen;
		logic                    abort;
		logic                    chk_pend;
		logic                    par_exp;
		pci_arb_pkg::pin_drive_t perr;
		pci_arb_pkg::pin_drive_t serr;
	} st_t;

	st_t st;
	st_t next_st;

	// Fixed scheme: master 0 highest. Rotating: first after the last granted.
	function automatic logic [1:0] pick(input logic [2:0] elig, input logic rr,
	                                    input logic [1:0] last);
		logic [1:0] idx;
		idx = 2'h0;
		if (rr) begin
			// Search starts just after the master served last
			case (last)
				2'h0: begin
					if (elig[1]) begin
						idx = 2'h1;
					end else if (elig[2]) begin
						idx = 2'h2;
					end else begin
						idx = 2'h0;
					end
				end
				2'h1: begin
					if (elig[2]) begin
						idx = 2'h2;
					end else if (elig[0]) begin
						idx = 2'h0;
					end else begin
						idx = 2'h1;
					end
				end
				2'h2: begin
					if (elig[0]) begin
						idx = 2'h0;
					end else if (elig[1]) begin
						idx = 2'h1;
					end else begin
						idx = 2'h2;
					end
				end
				default: begin
					if (elig[1]) begin
						idx = 2'h1;
					end else if (elig[2]) begin
						idx = 2'h2;
					end else begin
						idx = 2'h0;
					end
				end
			endcase
		end else begin
			if (elig[0]) begin
				idx = 2'h0;
			end else if (elig[1]) begin
				idx = 2'h1;
			end else if (elig[2]) begin
				idx = 2'h2;
			end
		end
		return idx;
	endfunction : pick

	// One low grant line per master index
	function automatic logic [2:0] grant_for(input logic [1:0] idx);
		logic [2:0] g;
		g = pci_arb_pkg::GNT_N_RESET;
		case (idx)
			2'h0: g = 3'h6;
			2'h1: g = 3'h5;
			2'h2: g = 3'h3;
			default: g = pci_arb_pkg::GNT_N_RESET;
		endcase
		return g;
	endfunction : grant_for

	// Any eligible request ahead of the current master in fixed order
	function automatic logic ahead(input logic [2:0] elig, input logic [1:0] cur);
		logic a;
		a = 1'b0;
		case (cur)
			2'h0: a = 1'b0;
			2'h1: a = elig[0];
			2'h2: a = |elig[1:0];
			default: a = |elig;
		endcase
		return a;
	endfunction : ahead

	always_comb begin
		logic [2:0] req;
		logic [2:0] elig;
		logic [1:0] win;
		logic       frame_start;
		logic       lock_start;
		logic       lock_end;
		logic       xfer;
		logic       is_read;
		logic       responsible;
		logic       par_bad;
		logic       higher;
		logic       drop_pri;
		logic       drop_tmo;
		logic       drop_req;
		logic       watch;
		logic       due;
		logic       lock_take;
		logic       perr_tail;
		req = 3'h0;
		elig = 3'h0;
		win = 2'h0;
		frame_start = 1'b0;
		lock_start = 1'b0;
		lock_end = 1'b0;
		xfer = 1'b0;
		is_read = 1'b0;
		responsible = 1'b0;
		par_bad = 1'b0;
		higher = 1'b0;
		drop_pri = 1'b0;
		drop_tmo = 1'b0;
		drop_req = 1'b0;
		watch = 1'b0;
		due = 1'b0;
		lock_take = 1'b0;
		perr_tail = 1'b0;
		next_st = st;

		// Two-stage capture of everything arriving from the bus
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.frame_q = st.s2.frame_n;
		next_st.lock_q = st.s2.lock_n;

		frame_start = st.frame_q && !st.s2.frame_n;
		lock_start = st.lock_q && !st.s2.lock_n;
		lock_end = !st.lock_q && st.s2.lock_n;

		// Lock ownership follows the lock handshake, not the grant
		lock_take = lock_start && st.arb == pci_arb_pkg::ARB_GRANTED;
		if (lock_take) begin
			next_st.lock_held = 1'b1;
			next_st.lock_owner = st.cur;
		end
		if (lock_end) begin
			next_st.lock_held = 1'b0;
		end

		// Without system lock mode a held lock does not block others
		req = ~st.s2.req_n;
		elig = req;
		if (sys_lock_en && st.lock_held) begin
			elig = req & ~grant_for(st.lock_owner);
		end
		win = pick(elig, arb_round_robin, st.rr_last);

		case (st.arb)
			pci_arb_pkg::ARB_IDLE: begin
				next_st.gnt_n = pci_arb_pkg::GNT_N_RESET;
				if (|elig) begin
					next_st.gnt_n = grant_for(win);
					next_st.cur = win;
					next_st.rr_last = win;
					next_st.tmo = 5'h00;
					next_st.started = 1'b0;
					next_st.arb = pci_arb_pkg::ARB_GRANTED;
				end
			end
			pci_arb_pkg::ARB_GRANTED: begin
				if (frame_start) begin
					next_st.started = 1'b1;
				end
				if (!st.started) begin
					next_st.tmo = st.tmo + 5'h01;
				end
				higher = ahead(elig, st.cur);
				// Rotating scheme has no higher requester by definition
				drop_pri = higher && !arb_round_robin;
				drop_tmo = !st.started && !frame_start
				           && st.tmo == pci_arb_pkg::GNT_TIMEOUT_LAST;
				// A dropped or refused request frees the bus at once
				drop_req = !elig[st.cur];
				if (drop_pri || drop_tmo || drop_req) begin
					next_st.gnt_n = pci_arb_pkg::GNT_N_RESET;
					next_st.arb = pci_arb_pkg::ARB_GAP;
				end
			end
			pci_arb_pkg::ARB_GAP: begin
				next_st.gnt_n = pci_arb_pkg::GNT_N_RESET;
				next_st.arb = pci_arb_pkg::ARB_IDLE;
			end
			default: begin
				next_st.gnt_n = pci_arb_pkg::GNT_N_RESET;
				next_st.arb = pci_arb_pkg::ARB_IDLE;
			end
		endcase

		// Transaction tracking: command taken at the address phase
		if (frame_start) begin
			next_st.cmd = st.s2.cbe_n;
			next_st.in_txn = 1'b1;
			next_st.mst_own = own_master_busy;
			next_st.dcnt = 3'h0;
			next_st.dsel_seen = 1'b0;
		end else if (st.s2.frame_n && st.s2.irdy_n) begin
			next_st.in_txn = 1'b0;
		end

		// Claim watch for own master cycles; it runs on after the bus goes
		// idle, so a short unclaimed cycle still ends in an abort
		next_st.abort = 1'b0;
		watch = st.mst_own && !frame_start;
		due = st.dcnt == pci_arb_pkg::SUBTRACTIVE_CLK - 3'h1;
		if (watch) begin
			if (!st.s2.devsel_n) begin
				next_st.dsel_seen = 1'b1;
			end
			if (st.dcnt != pci_arb_pkg::SUBTRACTIVE_CLK) begin
				next_st.dcnt = st.dcnt + 3'h1;
			end
			if (due && !st.dsel_seen && st.s2.devsel_n
			    && st.cmd != pci_arb_pkg::CMD_SPECIAL) begin
				next_st.abort = 1'b1;
			end
		end

		// Data phase parity: data at t, parity at t+1, report at t+2
		xfer = st.in_txn && !st.s2.irdy_n && !st.s2.trdy_n;
		is_read = !st.cmd[0];
		responsible = (is_read && st.mst_own)
		              || (!is_read && own_target_claim && !st.s2.devsel_n);
		next_st.chk_pend = xfer && responsible
		                   && st.cmd != pci_arb_pkg::CMD_SPECIAL;
		if (xfer) begin
			next_st.par_exp = ^{st.s2.ad, st.s2.cbe_n};
		end
		par_bad = st.chk_pend && (st.s2.par != st.par_exp);
		perr_tail = st.perr.oe && !st.perr.out;

		if (par_bad) begin
			next_st.perr = '{out: 1'b0, oe: 1'b1};
		end else if (perr_tail) begin
			next_st.perr = '{out: 1'b1, oe: 1'b1};
		end else begin
			next_st.perr = '{out: 1'b1, oe: 1'b0};
		end

		// Open drain: only ever pulls low
		next_st.serr.out = 1'b0;
		next_st.serr.oe = parity_check_en && dram_read_par_err;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st.s1 <= pci_arb_pkg::PINS_IDLE;
			st.s2 <= pci_arb_pkg::PINS_IDLE;
			st.frame_q <= 1'b1;
			st.lock_q <= 1'b1;
			st.arb <= pci_arb_pkg::ARB_IDLE;
			st.gnt_n <= pci_arb_pkg::GNT_N_RESET;
			st.cur <= pci_arb_pkg::MASTER_RESET;
			st.rr_last <= pci_arb_pkg::RR_LAST_RESET;
			st.tmo <= 5'h00;
			st.started <= 1'b0;
			st.lock_held <= 1'b0;
			st.lock_owner <= pci_arb_pkg::MASTER_RESET;
			st.cmd <= pci_arb_pkg::CMD_RESET;
			st.in_txn <= 1'b0;
			st.mst_own <= 1'b0;
			st.dcnt <= 3'h0;
			st.dsel_seen <= 1'b0;
			st.abort <= 1'b0;
			st.chk_pend <= 1'b0;
			st.par_exp <= 1'b0;
			st.perr <= '{out: 1'b1, oe: 1'b0};
			st.serr <= '{out: 1'b0, oe: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign gnt_n = st.gnt_n;
	assign perr_drive = st.perr;
	assign serr_drive = st.serr;
	assign master_abort = st.abort;
	assign lock_held = st.lock_held;
	assign lock_owner = st.lock_owner;

endmodule : pci_arbiter_lock_error

// ---- test/pci_arb_asserts.sv ----
`timescale 1ns/1ps
module pci_arb_asserts (
	input wire logic                    mclk,
	input wire logic                    srst,
	input wire logic                    parity_check_en,
	input wire logic                    dram_read_par_err,
	input wire logic                    sys_lock_en,
	input wire logic [2:0]              gnt_n,
	input wire pci_arb_pkg::pin_drive_t perr_drive,
	input wire pci_arb_pkg::pin_drive_t serr_drive,
	input wire logic                    master_abort,
	input wire logic                    lock_held,
	input wire logic [1:0]              lock_owner
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	one_grant_a: assert property ($onehot0(~gnt_n))
		else $error("two grants");
	grant_gap_a: assert property ($changed(gnt_n) && gnt_n != 3'h7 |-> $past(gnt_n) == 3'h7)
		else $error("grant moved without gap");
	serr_raise_a: assert property (dram_read_par_err && parity_check_en |=> serr_drive.oe)
		else $error("system error missing");
	serr_quiet_a: assert property (!(dram_read_par_err && parity_check_en) |=> !serr_drive.oe)
		else $error("spurious system error");
	serr_low_a: assert property (serr_drive.oe |-> !serr_drive.out)
		else $error("system error driven high");
	perr_hold_a: assert property (perr_drive.oe && !perr_drive.out |=> perr_drive.oe)
		else $error("parity error released while low");
	perr_release_a: assert property ($fell(perr_drive.oe) |-> $past(perr_drive.out))
		else $error("parity error released without high clock");
	lock_only_a: assert property (sys_lock_en && lock_held && gnt_n != 3'h7 |-> !gnt_n[lock_owner])
		else $error("grant to other master under lock");
	lock_grant_a: assert property ($rose(lock_held) |-> $past(gnt_n) != 3'h7)
		else $error("lock taken without grant");
	abort_pulse_a: assert property (master_abort |=> !master_abort)
		else $error("abort longer than one clock");
	cover property (master_abort);
	cover property (sys_lock_en && lock_held);
	cover property (perr_drive.oe && !perr_drive.out);
endmodule : pci_arb_asserts

bind pci_arbiter_lock_error pci_arb_asserts chk_u (.mclk, .srst, .parity_check_en,
	.dram_read_par_err, .sys_lock_en, .gnt_n, .perr_drive, .serr_drive, .master_abort,
	.lock_held, .lock_owner);

// ---- test/pci_bus_agent.sv ----
`timescale 1ns/1ps
module pci_bus_agent (
	input  wire logic             mclk,
	input  wire logic [2:0]       gnt_n,
	input  wire logic [2:0]       want,
	input  wire logic             go,
	input  wire logic             lk,
	input  wire logic             claim,
	input  wire logic             bad,
	input  wire logic [3:0]       cmd,
	output pci_arb_pkg::pci_pins_t pins
);
	logic [1:0] ph = 2'h0;
	initial pins = pci_arb_pkg::PINS_IDLE;
	always @(posedge mclk) begin
		pins.req_n <= ~want;
		pins.lock_n <= ~lk;
		case (ph)
			2'h0: begin
				// Only a granted master starts
				pins.frame_n <= !(go && gnt_n != 3'h7);
				pins.cbe_n <= cmd;
				pins.ad <= $urandom;
				pins.par <= ~pins.par;
				if (go && gnt_n != 3'h7)
					ph <= 2'h1;
			end
			2'h1: begin
				pins.frame_n <= 1'b1;
				pins.irdy_n <= 1'b0;
				// A target claims only when claim is set; otherwise nobody answers the data phase
				pins.trdy_n <= !claim;
				pins.devsel_n <= !claim;
				pins.cbe_n <= 4'h0;
				pins.ad <= $urandom;
				pins.par <= ^{pins.ad, pins.cbe_n};
				ph <= 2'h2;
			end
			default: begin
				pins.irdy_n <= 1'b1;
				pins.trdy_n <= 1'b1;
				pins.devsel_n <= 1'b1;
				pins.ad <= ~pins.ad;
				pins.par <= ^{pins.ad, pins.cbe_n} ^ bad;
				ph <= 2'h0;
			end
		endcase
	end
endmodule : pci_bus_agent

// ---- test/pci_arbiter_lock_error_tb.sv ----
`timescale 1ns/1ps
module pci_arbiter_lock_error_tb;
	logic mclk = 1'b0, srst = 1'b1, arb_round_robin = 1'b0, sys_lock_en = 1'b0;
	logic own_master_busy = 1'b0, own_target_claim = 1'b0;
	logic parity_check_en = 1'b0, dram_read_par_err = 1'b0;
	logic go = 1'b0, lk = 1'b0, claim = 1'b0, bad = 1'b0, master_abort, lock_held;
	logic [3:0] cmd = 4'h6, r;
	logic [1:0] ee;
	logic [2:0] want = 3'h0, gnt_n;
	logic [1:0] lock_owner;
	pci_arb_pkg::pci_pins_t pins;
	pci_arb_pkg::pin_drive_t perr_drive, serr_drive;
	int fails = 0, checks_done = 0, n, m;

	pci_arbiter_lock_error dut_u (.mclk, .srst, .pins, .arb_round_robin, .sys_lock_en,
		.own_master_busy, .own_target_claim, .parity_check_en, .dram_read_par_err,
		.gnt_n, .perr_drive, .serr_drive, .master_abort, .lock_held, .lock_owner);
	pci_bus_agent agent_u (.mclk, .gnt_n, .want, .go, .lk, .claim, .bad, .cmd, .pins);

	initial forever #12.5 mclk = ~mclk;

	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
		checks_done++;
		if (v !== e) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", s, e, v);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
	endtask : tick

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	function automatic logic [2:0] top_gnt(input logic [2:0] w);
		return w[0] ? 3'h6 : (w[1] ? 3'h5 : 3'h3);
	endfunction : top_gnt

	// {abort, parity error}; r: 0 own master, 1 own target, 2 claimed
	function automatic logic [1:0] exp_err(input logic [3:0] c, input logic [3:0] r,
		input logic b);
		logic sp;
		sp = (c == pci_arb_pkg::CMD_SPECIAL);
		return {r[0] && !r[2] && !sp, b && !sp && r[2] && (c[0] ? !r[0] && r[1] : r[0])};
	endfunction : exp_err

	// Whole run is under 2000 clocks
	initial begin
		#100us;
		fails++;
		conclude();
	end

	initial begin
		void'($urandom(1503));
		tick(4);
		srst <= 1'b0;
		#1 chk("gnt reset", 3'h7, gnt_n);
		for (int i = 0; i < 12; i++) begin
			r = 4'($urandom_range(1, 7));
			tick(1);
			arb_round_robin <= (i > 7);
			want <= r[2:0];
			tick(8);
			want <= 3'h0;
			#1 chk("grant", i > 7 ? 3'h1 : top_gnt(r[2:0]),
				i > 7 ? 3'({|(~gnt_n & r[2:0])}) : gnt_n);
			tick(6);
		end
		arb_round_robin <= 1'b0;
		want <= 3'h4;
		tick(8);
		want <= 3'h5;
		tick(8);
		#1 chk("preempt", 3'h6, gnt_n);
		tick(1);
		want <= 3'h0;
		tick(6);
		want <= 3'h2;
		m = 0;
		n = 0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			if (gnt_n === 3'h5 && n == 0)
				m++;
			if (gnt_n !== 3'h5 && m > 0)
				n = 1;
		end
		chk("grant span", 8'd16, 8'(m));
		tick(1);
		sys_lock_en <= 1'b1;
		go <= 1'b1;
		tick(8);
		#1 chk("lock by grant", 1'b0, lock_held);
		tick(1);
		lk <= 1'b1;
		tick(6);
		#1 chk("owner", 3'h5, {lock_held, lock_owner});
		tick(1);
		want <= 3'h3;
		tick(12);
		#1 chk("locked", 3'h5, gnt_n);
		tick(1);
		lk <= 1'b0;
		tick(10);
		#1 chk("unlocked", 3'h6, gnt_n);
		tick(1);
		sys_lock_en <= 1'b0;
		go <= 1'b0;
		want <= 3'h1;
		for (int i = 0; i < 32; i++) begin
			r = 4'($urandom);
			tick(1);
			cmd <= 4'(i);
			own_master_busy <= r[0];
			own_target_claim <= !r[0] && r[1];
			claim <= r[2];
			bad <= r[3] | !i[4];
			go <= 1'b1;
			repeat (20)
				if (pins.frame_n)
					@(posedge mclk);
			go <= 1'b0;
			m = 0;
			n = 0;
			repeat (16) begin
				@(posedge mclk);
				#1;
				n += master_abort;
				m += (perr_drive.oe && !perr_drive.out);
			end
			ee = exp_err(4'(i), r, r[3] | !i[4]);
			chk("abort", 8'(ee[1]), 8'(n));
			chk("perr", 8'(ee[0]), 8'(m));
		end
		for (int i = 0; i < 20; i++) begin
			r = 4'($urandom);
			tick(1);
			dram_read_par_err <= r[0];
			parity_check_en <= r[1];
			tick(1);
			dram_read_par_err <= 1'b0;
			#1 chk("serr", r[0] & r[1], serr_drive.oe);
		end
		conclude();
	end
endmodule : pci_arbiter_lock_error_tb
